// >>> shared/sea_params.svh
// Constants of the serial EEPROM access block: offsets, resets, timing.
// Assumes inclusion by bare name from a design or bench file.
`ifndef SEA_PARAMS_SVH
`define SEA_PARAMS_SVH
// ---------------------------------------------
// APB register offsets (byte addresses)
// ---------------------------------------------
`define SEA_OFS_CTRL 8'h00
`define SEA_OFS_STAT 8'h04
`define SEA_OFS_DATA 8'h08
// ---------------------------------------------
// Field positions and reset values
// ---------------------------------------------
`define SEA_CTRL_MON 0
`define SEA_STAT_BUSY 0
`define SEA_STAT_INIT 1
`define SEA_STAT_DROP 2
`define SEA_STAT_IDLE 3
`define SEA_DATA_VLD 8
`define SEA_CTRL_RST 1'h0
`define SEA_INIT_BYTE 8'hff
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define SEA_PROG_MS 10
`define SEA_CLK_MHZ 100
`define SEA_PROG_CYC (`SEA_PROG_MS * 1000 * `SEA_CLK_MHZ)
`define SEA_FIFO_DEPTH 32
`endif

// >>> shared/sea_pkg.sv
// Types of the serial EEPROM access block.
// Assumes nothing beyond a SystemVerilog compiler.
package sea_pkg;
  // Link protocol states, Gray along the usual path
  typedef enum logic [2:0] {
    SEA_IDLE = 3'h0,
    SEA_CTRL = 3'h1,
    SEA_CACK = 3'h3,
    SEA_WDAT = 3'h2,
    SEA_WACK = 3'h6,
    SEA_RDAT = 3'h7,
    SEA_RACK = 3'h5
  } sea_state_t;
  // Control byte layout, MSB first on the line
  typedef struct packed {
    logic [4:0] row_addr;
    logic order_mode_upper;
    logic order_mode_lower;
    logic read_not_write_dir;
  } sea_ctrl_t;
  // Sampled serial link pair
  typedef struct packed {
    logic scl;
    logic sda;
  } sea_link_t;
endpackage

// >>> design/sea_top.sv
// Serial EEPROM access logic: two-wire slave, 32x16 word store, APB view.
// Assumes an APB master on pclk and a two-wire master on the serial link.
//
// Summary of operation
// - Busy programming: ignore inputs, no acknowledge
// - Acknowledge polled control byte once idle
// - Write mode 01: first byte low
// - Write mode 10: first byte high
// - Read control: acknowledge, buffer word, send
// - After both bytes step row, reload
// - Row address wraps during sequential read
// - Read mode 01: low first, increment
// - Read mode 10: high first, decrement
// - Acknowledged FFh leaves interface idle
// - Control byte: row, mode, direction
// - Programming keeps device busy 10 ms
`timescale 1ns/10ps
`include "sea_params.svh"

// ---------------------------------------------
// Byte FIFO between link and APB
// ---------------------------------------------
module sea_fifo import sea_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic in_valid, // Push request
  output logic in_ready, // Room left
  input wire logic [WIDTH-1:0] in_data, // Push data
  output logic out_valid, // Data present
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic [AW:0] cnt;
  // Occupancy from pointer difference
  assign cnt = wp_reg - rp_reg;
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp_reg[AW-1:0]];
  // Storage write
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
  // Pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule // sea_fifo

// ---------------------------------------------
// Top: serial EEPROM access
// ---------------------------------------------
module sea_top import sea_pkg::*; #(
  parameter int PROG_CYCLES = `SEA_PROG_CYC
) (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic scl_in, // Serial link clock
  input wire logic sda_in, // Serial link data level
  output logic sda_out, // Data drive value, always low
  output logic sda_oe // Data drive enable, high pulls low
);
  // Byte taken from a word in transfer order
  function automatic logic [7:0] pick(input logic [15:0] w, input logic hi_first,
                                     input logic idx);
    pick = (hi_first ^ idx) ? w[15:8] : w[7:0];
  endfunction

  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  sea_link_t filt_reg;
  sea_link_t prev_reg;
  logic start_ev, stop_ev, rise_ev, fall_ev;
  sea_state_t st_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  sea_ctrl_t ctl_reg;
  logic [15:0] buf_reg;
  logic idx_reg;
  logic [1:0] wcnt_reg;
  logic wr_reg;
  logic ackd_reg;
  logic init_reg;
  logic [15:0] mem [0:31];
  logic [19:0] busy_reg;
  logic busy;
  logic hi_first;
  logic dec_mode;
  logic [4:0] row_next;
  logic commit;
  logic mon_reg;
  logic drop_reg;
  logic push_v;
  logic ack_ok;
  logic f_in_rdy, f_out_vld, f_pop;
  logic [7:0] f_out;
  logic acc;
  logic [7:0] tx_first;
  logic [7:0] tx_second;
  logic [7:0] tx_reload;

  // ---------------------------------------------
  // Link input synchronisers and event detect
  // ---------------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      filt_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], scl_in};
      sda_s_reg <= {sda_s_reg[1:0], sda_in};
      if (scl_s_reg[1] == scl_s_reg[2]) begin
        filt_reg.scl <= scl_s_reg[2];
      end
      if (sda_s_reg[1] == sda_s_reg[2]) begin
        filt_reg.sda <= sda_s_reg[2];
      end
      prev_reg <= filt_reg;
    end
  end
  // Start and stop are data edges while the clock stays high
  assign start_ev = filt_reg.scl & prev_reg.scl & prev_reg.sda & ~filt_reg.sda;
  assign stop_ev = filt_reg.scl & prev_reg.scl & ~prev_reg.sda & filt_reg.sda;
  assign rise_ev = filt_reg.scl & ~prev_reg.scl;
  assign fall_ev = ~filt_reg.scl & prev_reg.scl;

  // ---------------------------------------------
  // Mode decode and derived terms
  // ---------------------------------------------
  assign hi_first = ctl_reg.order_mode_upper & ~ctl_reg.order_mode_lower;
  assign dec_mode = hi_first;
  assign row_next = dec_mode ? ctl_reg.row_addr - 5'h1 : ctl_reg.row_addr + 5'h1;
  assign busy = (busy_reg != 20'h0);
  assign commit = stop_ev & wr_reg & (wcnt_reg != 2'h0) & ~busy;
  assign ack_ok = ~busy & (~mon_reg | f_in_rdy);
  // Bytes to send: both of the buffered word, and the first of the next row
  assign tx_first = pick(buf_reg, hi_first, 1'b0);
  assign tx_second = pick(buf_reg, hi_first, 1'b1);
  assign tx_reload = pick(mem[row_next], hi_first, 1'b0);

  // FIFO push: acked control and write bytes, read bytes at master ack
  always_comb begin
    push_v = 1'b0;
    if (mon_reg) begin
      if (fall_ev && bit_reg == 4'h8 && ack_ok) begin
        push_v = (st_reg == SEA_CTRL) || (st_reg == SEA_WDAT && wcnt_reg != 2'h2);
      end else if (rise_ev && st_reg == SEA_RACK) begin
        push_v = f_in_rdy;
      end
    end
  end

  // ---------------------------------------------
  // Link protocol state machine
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= SEA_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ctl_reg <= 8'h00;
      buf_reg <= 16'h0000;
      idx_reg <= 1'b0;
      wcnt_reg <= 2'h0;
      wr_reg <= 1'b0;
      ackd_reg <= 1'b0;
      init_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      // Every transfer and every poll opens here
      st_reg <= SEA_CTRL;
      bit_reg <= 4'h0;
      wr_reg <= 1'b0;
      wcnt_reg <= 2'h0;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= SEA_IDLE;
      wr_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (st_reg)
        SEA_CTRL: begin
          if (rise_ev) begin
            sh_reg <= {sh_reg[6:0], filt_reg.sda};
            bit_reg <= bit_reg + 4'h1;
          end else if (fall_ev && bit_reg == 4'h8) begin
            if (ack_ok) begin
              ctl_reg <= sh_reg;
              buf_reg <= mem[sh_reg[7:3]];
              sda_oe <= 1'b1;
              st_reg <= SEA_CACK;
            end else begin
              st_reg <= SEA_IDLE;
            end
          end
        end
        SEA_CACK: begin
          if (fall_ev) begin
            bit_reg <= 4'h0;
            idx_reg <= 1'b0;
            if (ctl_reg == `SEA_INIT_BYTE) begin
              sda_oe <= 1'b0;
              init_reg <= 1'b1;
              st_reg <= SEA_IDLE;
            end else if (ctl_reg.read_not_write_dir) begin
              // First byte of the word in the selected order
              sda_oe <= ~tx_first[7];
              tx_reg <= {tx_first[6:0], 1'b0};
              st_reg <= SEA_RDAT;
            end else begin
              sda_oe <= 1'b0;
              wr_reg <= 1'b1;
              st_reg <= SEA_WDAT;
            end
          end
        end
        SEA_WDAT: begin
          if (rise_ev) begin
            sh_reg <= {sh_reg[6:0], filt_reg.sda};
            bit_reg <= bit_reg + 4'h1;
          end else if (fall_ev && bit_reg == 4'h8) begin
            if (ack_ok && wcnt_reg != 2'h2) begin
              // Place byte by order mode
              if (pick(16'hff00, hi_first, wcnt_reg[0]) == 8'hff) begin
                buf_reg[15:8] <= sh_reg;
              end else begin
                buf_reg[7:0] <= sh_reg;
              end
              wcnt_reg <= wcnt_reg + 2'h1;
              sda_oe <= 1'b1;
              st_reg <= SEA_WACK;
            end else begin
              st_reg <= SEA_IDLE;
            end
          end
        end
        SEA_WACK: begin
          if (fall_ev) begin
            sda_oe <= 1'b0;
            bit_reg <= 4'h0;
            st_reg <= SEA_WDAT;
          end
        end
        SEA_RDAT: begin
          if (rise_ev) begin
            bit_reg <= bit_reg + 4'h1;
          end else if (fall_ev) begin
            if (bit_reg == 4'h8) begin
              sda_oe <= 1'b0;
              st_reg <= SEA_RACK;
            end else begin
              sda_oe <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        SEA_RACK: begin
          if (rise_ev) begin
            ackd_reg <= ~filt_reg.sda;
          end else if (fall_ev) begin
            bit_reg <= 4'h0;
            if (!ackd_reg) begin
              st_reg <= SEA_IDLE;
            end else if (!idx_reg) begin
              idx_reg <= 1'b1;
              sda_oe <= ~tx_second[7];
              tx_reg <= {tx_second[6:0], 1'b0};
              st_reg <= SEA_RDAT;
            end else begin
              // Word done: step row, reload, continue
              idx_reg <= 1'b0;
              ctl_reg.row_addr <= row_next;
              buf_reg <= mem[row_next];
              sda_oe <= ~tx_reload[7];
              tx_reg <= {tx_reload[6:0], 1'b0};
              st_reg <= SEA_RDAT;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Transmit bytes also go to the FIFO at master ack
  logic [7:0] push_d;
  assign push_d = (st_reg == SEA_RACK) ? pick(buf_reg, hi_first, idx_reg) : sh_reg;

  // ---------------------------------------------
  // Word store and programming timer
  // ---------------------------------------------
  always_ff @(posedge pclk) begin
    if (commit) begin
      mem[ctl_reg.row_addr] <= buf_reg;
    end
  end
  // Erase plus write time; inputs refused meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 20'h0;
    end else if (commit) begin
      busy_reg <= 20'(PROG_CYCLES);
    end else if (busy) begin
      busy_reg <= busy_reg - 20'h1;
    end
  end

  // Data line value is always low; the enable does the work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Byte FIFO
  // ---------------------------------------------
  sea_fifo #(.WIDTH(8), .DEPTH(`SEA_FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_v),
    .in_ready(f_in_rdy),
    .in_data(push_d),
    .out_valid(f_out_vld),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  // ---------------------------------------------
  // APB slave
  // ---------------------------------------------
  assign acc = psel & penable & ~pready;
  assign f_pop = acc & ~pwrite & (paddr == `SEA_OFS_DATA);
  // One wait state, then ready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (acc) begin
        case (paddr)
          `SEA_OFS_CTRL: prdata[`SEA_CTRL_MON] <= mon_reg;
          `SEA_OFS_STAT: begin
            prdata[`SEA_STAT_BUSY] <= busy;
            prdata[`SEA_STAT_INIT] <= init_reg;
            prdata[`SEA_STAT_DROP] <= drop_reg;
            prdata[`SEA_STAT_IDLE] <= (st_reg == SEA_IDLE);
          end
          `SEA_OFS_DATA: prdata[8:0] <= {f_out_vld, f_out_vld ? f_out : 8'h00};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // Monitor enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_reg <= `SEA_CTRL_RST;
    end else if (acc && pwrite && paddr == `SEA_OFS_CTRL) begin
      mon_reg <= pwdata[`SEA_CTRL_MON];
    end
  end
  // Lost read byte flag: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_reg <= 1'b0;
    end else if (mon_reg && rise_ev && st_reg == SEA_RACK && !f_in_rdy) begin
      drop_reg <= 1'b1;
    end else if (acc && pwrite && paddr == `SEA_OFS_STAT && pwdata[`SEA_STAT_DROP]) begin
      drop_reg <= 1'b0;
    end
  end
endmodule // sea_top

// >>> dv/sea_top_properties.sv
// Port checks for the serial EEPROM access block.
// Assumes binding to sea_top; sees only its ports.
`timescale 1ns/10ps
`include "sea_params.svh"
module sea_top_properties #(
  parameter int PROG_CYCLES = `SEA_PROG_CYC
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic scl_in, // Link clock
  input wire logic sda_in, // Link data
  input wire logic sda_out, // Drive value
  input wire logic sda_oe // Drive enable
);
  logic mapped;
  // Offsets that decode to a register
  assign mapped = paddr == `SEA_OFS_CTRL || paddr == `SEA_OFS_STAT || paddr == `SEA_OFS_DATA;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle followed by first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  a_one_wait: assert property (s_access |=> pready)
    else $error("ready missing after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready without access");
  a_err_unmapped: assert property (pslverr |-> pready && !mapped)
    else $error("error on mapped offset");
  a_unmapped_zero: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_quiet_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  a_ctrl_bits: assert property (pready && !pwrite && paddr == `SEA_OFS_CTRL |->
    prdata[31:1] == 31'h0) else $error("control unused bits set");
  a_stat_bits: assert property (pready && !pwrite && paddr == `SEA_OFS_STAT |->
    prdata[31:4] == 28'h0) else $error("status unused bits set");
  a_data_fields: assert property (pready && !pwrite && paddr == `SEA_OFS_DATA |->
    prdata[31:9] == 23'h0 && (prdata[8] || prdata[7:0] == 8'h0)) else $error("data word bad");
  a_drive_low: assert property (sda_oe |-> !sda_out) else $error("line driven high");
  a_edge_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
endmodule // sea_top_properties
bind sea_top sea_top_properties #(.PROG_CYCLES(PROG_CYCLES)) sea_top_properties_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe);

// >>> dv/sea_mst.sv
// Behavioural two-wire master driving the serial link.
// Assumes the bench calls its tasks one at a time; the clock rests high.
`timescale 1ns/10ps
module sea_mst (
  output logic scl, // Link clock, still between frames
  output logic sda, // Resolved data line
  input wire logic oe, // Device drive enable
  input wire logic dout // Device drive value
);
  logic m_low = 1'b0;
  initial scl = 1'b1;
  // Pull-up line, either party may pull it low
  assign sda = !m_low && !(oe && !dout);
  // Start: data falls while clock high
  task automatic start();
    m_low = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 m_low = 1'b1;
    #31.25 scl = 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    m_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 m_low = 1'b0;
    #62.5;
  endtask
  // One clock: data set while low, sampled while high
  task automatic bit_x(input logic b, output logic r);
    m_low = !b;
    #31.25 scl = 1'b1;
    #31.25 r = sda;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // Byte MSB first, then one acknowledge clock
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Ack continues a read, nack ends it
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, r);
  endtask
endmodule // sea_mst

// >>> dv/sea_top_test.sv
// Self-checking bench for the serial EEPROM access block.
// Assumes the master model and checker are compiled before it.
`timescale 1ns/10ps
`include "sea_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module sea_top_test import sea_pkg::*; ;
  localparam int PROG = 400;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, scl, sda, sda_out, sda_oe, ack, err;
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #5 pclk = ~pclk;
  sea_top #(.PROG_CYCLES(PROG)) sea_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe);
  sea_mst sea_mst_i (.scl(scl), .sda(sda), .oe(sda_oe), .dout(sda_out));
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // One APB transfer; waits for ready, keeps answer in q and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Control byte only, then stop
  task automatic poll(input logic [7:0] c, input logic exp);
    sea_mst_i.start();
    sea_mst_i.send(c, ack);
    sea_mst_i.stop();
    `CHK(ack, exp);
  endtask
  // Write a row, see it refused while busy, then accepted
  task automatic wr_row(input logic [4:0] r, input logic [1:0] m, input logic [7:0] b1,
    input logic [7:0] b2, input int n);
    sea_ctrl_t c;
    c = {r, m, 1'b0};
    sea_mst_i.start();
    sea_mst_i.send(c, ack);
    `CHK(ack, 1'b1);
    sea_mst_i.send(b1, ack);
    `CHK(ack, 1'b1);
    if (n == 2) begin
      sea_mst_i.send(b2, ack);
      `CHK(ack, 1'b1);
    end
    sea_mst_i.stop();
    rd(`SEA_OFS_STAT);
    `CHK(q[0], 1'b1);
    poll(c, 1'b0);
    q = 32'h1;
    while (q[0] !== 1'b0) rd(`SEA_OFS_STAT);
    poll(c, 1'b1);
  endtask
  // Read four bytes, the words of a row and of the row the mode steps to (next or previous), and compare them in order
  task automatic rd_rows(input logic [4:0] r, input logic [1:0] m, input logic [31:0] e);
    logic [7:0] b;
    sea_mst_i.start();
    sea_mst_i.send({r, m, 1'b1}, ack);
    `CHK(ack, 1'b1);
    for (int i = 3; i >= 0; i--) begin
      sea_mst_i.recv(i != 0, b);
      `CHK(b, e[i*8 +: 8]);
    end
    sea_mst_i.stop();
  endtask
  task automatic t_reset();
    rd(`SEA_OFS_CTRL);
    `CHK(q, 32'h0);
    rd(`SEA_OFS_STAT);
    `CHK(q, 32'h8);
    rd(8'h0c);
    `CHK({err, q}, 33'h100000000);
  endtask
  task automatic t_init();
    poll(`SEA_INIT_BYTE, 1'b1);
    rd(`SEA_OFS_STAT);
    `CHK(q, 32'ha);
  endtask
  task automatic t_writes();
    wr_row(5'h00, 2'b01, 8'h11, 8'h22, 2);
    wr_row(5'h01, 2'b10, 8'h33, 8'h44, 2);
    wr_row(5'h1f, 2'b01, 8'h55, 8'h66, 2);
    wr_row(5'h01, 2'b01, 8'h77, 8'h00, 1);
  endtask
  task automatic t_reads();
    rd_rows(5'h00, 2'b01, 32'h11227733);
    rd_rows(5'h00, 2'b10, 32'h22116655);
    rd_rows(5'h1f, 2'b01, 32'h55661122);
    rd_rows(5'h01, 2'b10, 32'h33772211);
    // Mode 11 falls back to low first, incrementing
    rd_rows(5'h00, 2'b11, 32'h11227733);
  endtask
  // Monitor fills until bytes are lost, then drains to empty
  task automatic t_fifo();
    logic [7:0] b;
    logic [31:0] e;
    apb(1'b1, `SEA_OFS_CTRL, 32'h1);
    rd(`SEA_OFS_CTRL);
    `CHK(q, 32'h1);
    sea_mst_i.start();
    sea_mst_i.send(8'h03, ack);
    `CHK(ack, 1'b1);
    for (int i = 0; i < 36; i++) sea_mst_i.recv(i != 35, b);
    sea_mst_i.stop();
    rd(`SEA_OFS_STAT);
    `CHK(q, 32'he);
    poll(8'h03, 1'b0);
    rd(`SEA_OFS_DATA);
    `CHK(q, 32'h103);
    // Rows 0 and 1 were written earlier; their bytes come first in read order
    e = 32'h11227733;
    for (int i = 3; i >= 0; i--) begin
      rd(`SEA_OFS_DATA);
      `CHK(q, {24'h1, e[i*8 +: 8]});
    end
    for (int i = 0; i < 27; i++) begin
      rd(`SEA_OFS_DATA);
      `CHK(q[8], 1'b1);
    end
    rd(`SEA_OFS_DATA);
    `CHK(q, 32'h0);
    apb(1'b1, `SEA_OFS_STAT, 32'h4);
    rd(`SEA_OFS_STAT);
    `CHK(q, 32'ha);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_init();
    t_writes();
    t_reads();
    t_fifo();
    end_of_test();
  end
endmodule // sea_top_test
